//--- src/dtc_timer_pair.v
// Top of the dual 16-bit timer/counter pair with its register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Timer function counts once per machine cycle of twelve clocks.
// - Counter function counts a high sample followed by a low sample.
// - Mode 00: high byte counts behind a divide-by-32 prescaler.
// - Mode 01: high and low bytes form one 16-bit counter.
// - Mode 10: low byte counts and reloads from high byte on overflow.
// - Mode 11 on timer zero: low byte own timer, high byte uses timer one.
// - Mode 11 on timer one stops it and holds its count.
// - Timer zero split: timer one sets no flag but still ticks the rate output.
// - Overflow to zero or to the reload value sets the overflow flag.
// - Gating set: count only while irq pin high and run bit set.
// - Function-select bit clear picks machine cycles, set picks the count pin.
// - Mode register: timer one bits 7..4, timer zero bits 3..0.
// - Each timer counts only while its run bit is set; timer zero's split high byte runs on timer one's run bit.
// - Overflow flags set by hardware, cleared when the interrupt is serviced.

module dtc_timer_pair
(
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] sfrAddr,
  input  wire       sfrWrEn,
  input  wire       sfrRdEn,
  input  wire [7:0] sfrWrData,
  output reg  [7:0] sfrRdData,
  input  wire       countInputZero,
  input  wire       countInputOne,
  input  wire       extIrqPinZero,
  input  wire       extIrqPinOne,
  input  wire       irqAckZero,
  input  wire       irqAckOne,
  output reg        overflowFlagZero,
  output reg        overflowFlagOne,
  output reg        serialRateTick
);

`include "dtc_defs.vh"

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0]  modeCtl_r;
  reg         runZero_r;
  reg         runOne_r;
  reg  [7:0]  lowZero_r;
  reg  [7:0]  highZero_r;
  reg  [7:0]  lowOne_r;
  reg  [7:0]  highOne_r;
  reg  [3:0]  mcCnt_r;
  reg         mcTick_r;

  reg  [7:0]  lowZero_nxt;
  reg  [7:0]  highZero_nxt;
  reg  [7:0]  lowOne_nxt;
  reg  [7:0]  highOne_nxt;
  reg         ovfZero;
  reg         ovfOne;
  reg         ovfSplitHigh;
  reg  [16:0] stepZero;
  reg  [16:0] stepOne;
  reg  [8:0]  splitLow;
  reg  [8:0]  splitHigh;

  wire [3:0]  grpZero;
  wire [3:0]  grpOne;
  wire [1:0]  modeZero;
  wire [1:0]  modeOne;
  wire        fallZero;
  wire        fallOne;
  wire        enZero;
  wire        enOne;
  wire        evZero;
  wire        evOne;
  wire        splitOn;
  wire        wrSel;
  wire        setFlagZero;
  wire        setFlagOne;

  // --------------------------------------------------------------------------
  // Machine-cycle divider
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      mcCnt_r  <= `DTC_MC_CNT_ZERO;
      mcTick_r <= 1'b0;
    end
    else
    begin
      mcTick_r <= (mcCnt_r == `DTC_MC_CNT_LAST);
      if (mcCnt_r == `DTC_MC_CNT_LAST)
        mcCnt_r <= `DTC_MC_CNT_ZERO;
      else
        mcCnt_r <= mcCnt_r + `DTC_MC_CNT_ONE;
    end
  end

  // --------------------------------------------------------------------------
  // Count-pin samplers
  // --------------------------------------------------------------------------
  dtc_fall_detect uFallZero
  (
    .clk      (clk),
    .rstn     (rstn),
    .sampleEn (mcTick_r),
    .countPin (countInputZero),
    .fallSeen (fallZero)
  );

  dtc_fall_detect uFallOne
  (
    .clk      (clk),
    .rstn     (rstn),
    .sampleEn (mcTick_r),
    .countPin (countInputOne),
    .fallSeen (fallOne)
  );

  // --------------------------------------------------------------------------
  // Count enables
  // --------------------------------------------------------------------------
  assign grpOne   = modeCtl_r[`DTC_GRP_ONE_HI:`DTC_GRP_ONE_LO];
  assign grpZero  = modeCtl_r[`DTC_GRP_ZERO_HI:`DTC_GRP_ZERO_LO];
  assign modeZero = grpZero[`DTC_GRP_MODE_HI:`DTC_GRP_MODE_LO];
  assign modeOne  = grpOne[`DTC_GRP_MODE_HI:`DTC_GRP_MODE_LO];
  assign splitOn  = (modeZero == `DTC_MODE_SPLIT);

  assign enZero = runZero_r & (~grpZero[`DTC_GRP_GATE] | extIrqPinZero);
  assign enOne  = runOne_r & (~grpOne[`DTC_GRP_GATE] | extIrqPinOne);

  // The sampler's pulse lands one clock after the machine-cycle tick, so the
  // counter function increments in the cycle after the sample is taken.
  assign evZero = enZero & (grpZero[`DTC_GRP_FUNC] ? fallZero : mcTick_r);
  assign evOne  = enOne & (grpOne[`DTC_GRP_FUNC] ? fallOne : mcTick_r);

  // --------------------------------------------------------------------------
  // Shared count step for modes 00, 01 and 10
  // --------------------------------------------------------------------------
  // Returns {overflow, high, low} after one increment.
  function [16:0] stepCount;
    input [1:0] md;
    input [7:0] hi;
    input [7:0] lo;
    reg   [8:0] sum;
    begin
      sum       = {1'b0, hi} + {1'b0, `DTC_BYTE_ONE};
      stepCount = {1'b0, hi, lo};
      case (md)
        `DTC_MODE_PRESCALE:
        begin
          // Only the low five bits prescale; the upper three are left alone.
          if (lo[4:0] == `DTC_PRESCALE_MAX)
            stepCount = {sum[8], sum[7:0], lo[7:5], `DTC_PRESCALE_ZERO};
          else
            stepCount = {1'b0, hi, lo[7:5], lo[4:0] + `DTC_PRESCALE_ONE};
        end
        `DTC_MODE_16BIT:
          stepCount = {1'b0, hi, lo} + `DTC_WORD_ONE;
        `DTC_MODE_RELOAD:
        begin
          if (lo == `DTC_BYTE_MAX)
            stepCount = {1'b1, hi, hi};
          else
            stepCount = {1'b0, hi, lo + `DTC_BYTE_ONE};
        end
        default:
          stepCount = {1'b0, hi, lo};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Next count values
  // --------------------------------------------------------------------------
  assign wrSel = sfrWrEn;

  always @*
  begin
    stepZero     = stepCount(modeZero, highZero_r, lowZero_r);
    stepOne      = stepCount(modeOne, highOne_r, lowOne_r);
    splitLow     = {1'b0, lowZero_r} + {1'b0, `DTC_BYTE_ONE};
    splitHigh    = {1'b0, highZero_r} + {1'b0, `DTC_BYTE_ONE};
    lowZero_nxt  = lowZero_r;
    highZero_nxt = highZero_r;
    lowOne_nxt   = lowOne_r;
    highOne_nxt  = highOne_r;
    ovfZero      = 1'b0;
    ovfOne       = 1'b0;
    ovfSplitHigh = 1'b0;

    if (splitOn)
    begin
      if (evZero)
      begin
        lowZero_nxt = splitLow[7:0];
        ovfZero     = splitLow[8];
      end
      // The split high byte is a pure machine-cycle timer on timer one's run bit.
      if (mcTick_r && runOne_r)
      begin
        highZero_nxt = splitHigh[7:0];
        ovfSplitHigh = splitHigh[8];
      end
    end
    else if (evZero)
    begin
      highZero_nxt = stepZero[15:8];
      lowZero_nxt  = stepZero[7:0];
      ovfZero      = stepZero[16];
    end

    // Timer one holds its count in mode 11.
    if (evOne && (modeOne != `DTC_MODE_SPLIT))
    begin
      highOne_nxt = stepOne[15:8];
      lowOne_nxt  = stepOne[7:0];
      ovfOne      = stepOne[16];
    end

    // A software write to a count byte takes precedence over the increment.
    if (wrSel && (sfrAddr == `DTC_ADDR_LOW_ZERO))
      lowZero_nxt = sfrWrData;
    if (wrSel && (sfrAddr == `DTC_ADDR_HIGH_ZERO))
      highZero_nxt = sfrWrData;
    if (wrSel && (sfrAddr == `DTC_ADDR_LOW_ONE))
      lowOne_nxt = sfrWrData;
    if (wrSel && (sfrAddr == `DTC_ADDR_HIGH_ONE))
      highOne_nxt = sfrWrData;
  end

  assign setFlagZero = ovfZero;
  assign setFlagOne  = (ovfOne & ~splitOn) | ovfSplitHigh;

  // --------------------------------------------------------------------------
  // Registers and flags
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      modeCtl_r        <= `DTC_MODE_RESET;
      runZero_r        <= 1'b0;
      runOne_r         <= 1'b0;
      lowZero_r        <= `DTC_BYTE_RESET;
      highZero_r       <= `DTC_BYTE_RESET;
      lowOne_r         <= `DTC_BYTE_RESET;
      highOne_r        <= `DTC_BYTE_RESET;
      overflowFlagZero <= 1'b0;
      overflowFlagOne  <= 1'b0;
      serialRateTick   <= 1'b0;
    end
    else
    begin
      lowZero_r  <= lowZero_nxt;
      highZero_r <= highZero_nxt;
      lowOne_r   <= lowOne_nxt;
      highOne_r  <= highOne_nxt;

      // Timer one still paces the serial rate while timer zero is split.
      serialRateTick <= ovfOne;

      if (wrSel && (sfrAddr == `DTC_ADDR_MODE))
        modeCtl_r <= sfrWrData;

      // A hardware set in the same cycle as any clear always wins.
      if (wrSel && (sfrAddr == `DTC_ADDR_RUN_FLAG))
      begin
        runZero_r        <= sfrWrData[`DTC_BIT_RUN_ZERO];
        runOne_r         <= sfrWrData[`DTC_BIT_RUN_ONE];
        overflowFlagZero <= setFlagZero | (sfrWrData[`DTC_BIT_FLAG_ZERO] & ~irqAckZero);
        overflowFlagOne  <= setFlagOne | (sfrWrData[`DTC_BIT_FLAG_ONE] & ~irqAckOne);
      end
      else
      begin
        overflowFlagZero <= setFlagZero | (overflowFlagZero & ~irqAckZero);
        overflowFlagOne  <= setFlagOne | (overflowFlagOne & ~irqAckOne);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Read data is registered so the output comes from a flop; it appears one
  // clock after the read strobe and holds until the next read.
  always @(posedge clk)
  begin
    if (!rstn)
      sfrRdData <= `DTC_RD_UNMAPPED;
    else if (sfrRdEn)
    begin
      case (sfrAddr)
        `DTC_ADDR_MODE:      sfrRdData <= modeCtl_r;
        `DTC_ADDR_RUN_FLAG:  sfrRdData <= {overflowFlagOne, runOne_r, overflowFlagZero, runZero_r, 4'h0};
        `DTC_ADDR_LOW_ZERO:  sfrRdData <= lowZero_r;
        `DTC_ADDR_HIGH_ZERO: sfrRdData <= highZero_r;
        `DTC_ADDR_LOW_ONE:   sfrRdData <= lowOne_r;
        `DTC_ADDR_HIGH_ONE:  sfrRdData <= highOne_r;
        default:             sfrRdData <= `DTC_RD_UNMAPPED;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- src/dtc_defs.vh
// Constants for the dual timer/counter pair: register addresses, field positions and timing.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// ----------------------------------------------------------------------------
// Register addresses on the special-function register port
// ----------------------------------------------------------------------------
`define DTC_ADDR_RUN_FLAG   8'h88
`define DTC_ADDR_MODE       8'h89
`define DTC_ADDR_LOW_ZERO   8'h8A
`define DTC_ADDR_LOW_ONE    8'h8B
`define DTC_ADDR_HIGH_ZERO  8'h8C
`define DTC_ADDR_HIGH_ONE   8'h8D

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DTC_MODE_RESET      8'h00
`define DTC_BYTE_RESET      8'h00
`define DTC_RD_UNMAPPED     8'h00

// ----------------------------------------------------------------------------
// Run and flag register bit positions
// ----------------------------------------------------------------------------
`define DTC_BIT_FLAG_ONE    7
`define DTC_BIT_RUN_ONE     6
`define DTC_BIT_FLAG_ZERO   5
`define DTC_BIT_RUN_ZERO    4

// ----------------------------------------------------------------------------
// Mode register fields: timer one in the upper group, timer zero in the lower
// ----------------------------------------------------------------------------
`define DTC_GRP_ONE_HI      7
`define DTC_GRP_ONE_LO      4
`define DTC_GRP_ZERO_HI     3
`define DTC_GRP_ZERO_LO     0
`define DTC_GRP_GATE        3
`define DTC_GRP_FUNC        2
`define DTC_GRP_MODE_HI     1
`define DTC_GRP_MODE_LO     0

// ----------------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------------
`define DTC_MODE_PRESCALE   2'b00
`define DTC_MODE_16BIT      2'b01
`define DTC_MODE_RELOAD     2'b10
`define DTC_MODE_SPLIT      2'b11

// ----------------------------------------------------------------------------
// Counting constants
// ----------------------------------------------------------------------------
`define DTC_OSC_PER_MC      12
`define DTC_MC_CNT_LAST     4'hB
`define DTC_MC_CNT_ZERO     4'h0
`define DTC_MC_CNT_ONE      4'h1
`define DTC_PRESCALE_MAX    5'h1F
`define DTC_PRESCALE_ONE    5'h01
`define DTC_PRESCALE_ZERO   5'h00
`define DTC_BYTE_MAX        8'hFF
`define DTC_BYTE_ONE        8'h01
`define DTC_WORD_ONE        17'h0_0001

`endif

//--- src/dtc_fall_detect.v
// Count-pin sampler that flags a high sample followed by a low sample.
`timescale 1ns/1ps
`default_nettype none

module dtc_fall_detect
(
  input  wire clk,
  input  wire rstn,
  input  wire sampleEn,
  input  wire countPin,
  output reg  fallSeen
);

  reg lastSample_r;

  // --------------------------------------------------------------------------
  // Sampling once per machine cycle
  // --------------------------------------------------------------------------
  // A level shorter than one machine cycle may fall between two samples and be
  // missed entirely; the source is expected to hold each level that long.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      lastSample_r <= 1'b0;
      fallSeen     <= 1'b0;
    end
    else if (sampleEn)
    begin
      lastSample_r <= countPin;
      fallSeen     <= lastSample_r & ~countPin;
    end
    else
    begin
      fallSeen <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- sim/dtc_timer_checker.sv
// Concurrent checks on the ports of the timer pair top.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_checker
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  input wire logic       countInputZero,
  input wire logic       countInputOne,
  input wire logic       extIrqPinZero,
  input wire logic       extIrqPinOne,
  input wire logic       irqAckZero,
  input wire logic       irqAckOne,
  input wire logic       overflowFlagZero,
  input wire logic       overflowFlagOne,
  input wire logic       serialRateTick
);
  // Mode and run bits are rebuilt from writes, since the top hides them.
  logic [7:0] mode_r;
  logic [1:0] run_r;
  always @(posedge clk)
    if (!rstn)
    begin
      mode_r <= 8'h00;
      run_r <= 2'b00;
    end
    else if (sfrWrEn && sfrAddr == 8'h88)
      run_r <= {sfrWrData[6], sfrWrData[4]};
    else if (sfrWrEn && sfrAddr == 8'h89)
      mode_r <= sfrWrData;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence quietAck;
    !run_r[0] ##1 !run_r[0] && irqAckZero && !sfrWrEn;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    !rstn |=> !overflowFlagZero && !overflowFlagOne && !serialRateTick) else $error("outputs not clear after reset");
  rd_unmapped_a: assert property (
    sfrRdEn && (sfrAddr < 8'h88 || sfrAddr > 8'h8D) |=> sfrRdData == 8'h00) else $error("unmapped read not zero");
  rd_flags_a: assert property (
    sfrRdEn && sfrAddr == 8'h88 |=> sfrRdData[3:0] == 4'h0 && sfrRdData[7] == $past(overflowFlagOne))
    else $error("run and flag readback wrong");
  tick_gap_a: assert property (
    serialRateTick |=> !serialRateTick [*8]) else $error("overflow ticks too close");
  tick_flag_a: assert property (
    serialRateTick && $past(mode_r[1:0]) != 2'b11 |-> overflowFlagOne) else $error("overflow without flag");
  stop_hold_a: assert property (
    $past(mode_r[5:4]) == 2'b11 |-> !serialRateTick) else $error("stopped timer ticked");
  flag_sticky_a: assert property (
    overflowFlagZero && !irqAckZero && !(sfrWrEn && sfrAddr == 8'h88) |=> overflowFlagZero)
    else $error("flag dropped by itself");
  ack_clear_a: assert property (
    quietAck |=> !overflowFlagZero) else $error("service did not clear flag");
endmodule
bind dtc_timer_pair dtc_timer_checker u_chk
(
  .clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
  .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .countInputZero(countInputZero),
  .countInputOne(countInputOne), .extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne),
  .irqAckZero(irqAckZero), .irqAckOne(irqAckOne), .overflowFlagZero(overflowFlagZero),
  .overflowFlagOne(overflowFlagOne), .serialRateTick(serialRateTick)
);
`default_nettype wire

//--- sim/dtc_pin_model.sv
// Event source for the count pins.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model
(
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] edges,
  output wire logic       pin,
  output wire logic       busy
);
  logic [7:0] left_r;
  logic [4:0] hold_r;
  logic       level_r = 1'b1;
  logic       busy_r = 1'b0;
  assign pin = level_r;
  assign busy = busy_r;
  // Each level stands 13 clocks, so a twelve-clock sampler sees it at least once.
  always @(posedge clk)
    if (start)
    begin
      left_r <= edges;
      hold_r <= 5'h0C;
      busy_r <= 1'b1;
      level_r <= 1'b1;
    end
    else if (busy_r)
      if (hold_r != 5'h00)
        hold_r <= hold_r - 5'h01;
      else
      begin
        hold_r <= 5'h0C;
        level_r <= ~level_r;
        left_r <= left_r - {7'h00, level_r};
        busy_r <= !(level_r && left_r == 8'h01);
      end
endmodule
`default_nettype wire

//--- sim/dtc_timer_pair_test.sv
// Self-checking bench for the timer pair.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dtc_timer_pair_test;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic [7:0] edges = 8'h00;
  logic       wrEn = 1'b0;
  logic       rdEn = 1'b0;
  logic       gateZero = 1'b0;
  logic       ackZero = 1'b0;
  logic       ackOne = 1'b0;
  logic       start = 1'b0;
  wire  [7:0] rdData;
  wire        pin, busy, flagZero, flagOne, tick;
  int         checks = 0;
  int         miscompares = 0;
  int         ticks = 0;
  int         n;
  always #20 clk = ~clk;
  always @(negedge clk)
    if (tick === 1'b1)
      ticks++;
  dtc_timer_pair u_dut
  (
    .clk(clk), .rstn(rstn), .sfrAddr(addr), .sfrWrEn(wrEn), .sfrRdEn(rdEn), .sfrWrData(wrData),
    .sfrRdData(rdData), .countInputZero(pin), .countInputOne(pin), .extIrqPinZero(gateZero),
    .extIrqPinOne(gateZero), .irqAckZero(ackZero), .irqAckOne(ackOne), .overflowFlagZero(flagZero),
    .overflowFlagOne(flagOne), .serialRateTick(tick)
  );
  dtc_pin_model u_pins (.clk(clk), .start(start), .edges(edges), .pin(pin), .busy(busy));
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle(1);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    idle(1);
    wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    idle(1);
    addr = a;
    rdEn = 1'b1;
    idle(1);
    rdEn = 1'b0;
    `CHK(rdData, e)
  endtask
  task automatic waitFor(input logic one, input int lim);
    for (n = 1; n < lim && (one ? flagOne : flagZero) !== 1'b1; n++)
      idle(1);
    `CHK(one ? flagOne : flagZero, 1'b1)
  endtask
  task automatic pulses(input logic [7:0] k);
    edges = k;
    start = 1'b1;
    idle(1);
    start = 1'b0;
    for (n = 0; n < 400 && busy !== 1'b0; n++)
      idle(1);
    `CHK(busy, 1'b0)
    idle(30);
  endtask
  task automatic t_regs;
    for (int a = 8'h86; a <= 8'h8E; a++)
      rd(a[7:0], 8'h00);
    wr(8'h89, 8'hA5);
    rd(8'h89, 8'hA5);
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'hF0);
    wr(8'h88, 8'h00);
    wr(8'h8E, 8'h5A);
    rd(8'h8E, 8'h00);
  endtask
  task automatic t_word;
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    idle(30);
    rd(8'h8A, 8'hFE);
    wr(8'h88, 8'h10);
    waitFor(1'b0, 40);
    `CHK(n >= 13 && n <= 26, 1'b1)
    wr(8'h88, 8'h20);
    rd(8'h8A, 8'h00);
    rd(8'h8C, 8'h00);
    ackZero = 1'b1;
    idle(1);
    ackZero = 1'b0;
    `CHK(flagZero, 1'b0)
  endtask
  task automatic t_pre;
    wr(8'h89, 8'h00);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    waitFor(1'b0, 30);
    wr(8'h88, 8'h00);
    `CHK(flagZero, 1'b0)
    rd(8'h8A, 8'hE0);
    rd(8'h8C, 8'h00);
  endtask
  task automatic t_reload;
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'h80);
    wr(8'h8B, 8'hFE);
    ticks = 0;
    wr(8'h88, 8'h40);
    waitFor(1'b1, 40);
    wr(8'h88, 8'h80);
    rd(8'h8B, 8'h80);
    rd(8'h8D, 8'h80);
    `CHK(ticks == 1, 1'b1)
    ackOne = 1'b1;
    idle(1);
    ackOne = 1'b0;
    `CHK(flagOne, 1'b0)
  endtask
  task automatic t_split;
    wr(8'h89, 8'h13);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h00);
    ticks = 0;
    wr(8'h88, 8'h40);
    for (n = 0; n < 20 && ticks == 0; n++)
      idle(1);
    `CHK(ticks, 1)
    `CHK(flagOne, 1'b0)
    waitFor(1'b1, 20);
    `CHK(flagZero, 1'b0)
    rd(8'h8A, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8B, 8'h55);
    idle(40);
    rd(8'h8B, 8'h55);
    wr(8'h88, 8'h00);
  endtask
  task automatic t_count;
    wr(8'h89, 8'hDD);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    pulses(8'h03);
    rd(8'h8A, 8'h00);
    rd(8'h8B, 8'h00);
    gateZero = 1'b1;
    pulses(8'h05);
    rd(8'h8A, 8'h05);
    rd(8'h8B, 8'h05);
    wr(8'h89, 8'h05);
    gateZero = 1'b0;
    pulses(8'h02);
    rd(8'h8A, 8'h07);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    idle(20);
    rstn = 1'b1;
    t_regs;
    t_word;
    t_pre;
    t_reload;
    t_split;
    t_count;
    wrap_up;
  end
  // The whole sequence needs about six hundred cycles.
  initial
  begin
    #(40 * 4000);
    miscompares++;
    wrap_up;
  end
endmodule
`default_nettype wire
